// File: loop_tuning_map.svh
// Constants for the loop tuning settings manager: timing counts, codes, reset values.
// Assumes a 10 MHz mclk_i; included by bare name.
`ifndef LOOP_TUNING_MAP_SVH
`define LOOP_TUNING_MAP_SVH
// ==========================================================
// Timing
`define CLK_HZ            10000000
`define TICK_US           1000
`define TICK_CYCLES       (`CLK_HZ / 1000000 * `TICK_US)
`define TUNE_MIN_MS       50
`define TUNE_MAX_MS       200
`define PERIOD_SEC_MS     1000
`define PERIOD_MIN_MS     60000
// ==========================================================
// Gain, percent
`define GAIN_MIN_PCT      7'h0a
`define GAIN_MAX_PCT      7'h64
`define GAIN_RST_PCT      7'h32
// ==========================================================
// Strap levels, millivolt codes
`define STRAP_LEVELS      28
`define VOUT_MIN_MV       12'h258
`define VOUT_MAX_MV       12'hce4
`define FIX_SHORT_MV      12'h258
`define FIX_OPEN_MV       12'h4b0
`define FIX_HIGH_MV       12'h9c4
`define LIMIT_NUM         11
`define LIMIT_DEN         10
// ==========================================================
// Coefficient width
`define COEFF_W           72
`endif

// File: loop_tuning_pkg.sv
// Types shared by the loop tuning settings manager.
// Assumes loop_tuning_map.svh is compiled beside it.
package loop_tuning_pkg;
	// ==========================================================
	// Tuning schedule choices
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_ONCE,
		MODE_SECOND,
		MODE_MINUTE
	} tune_mode_e;
	// Strap pin condition
	typedef enum logic [1:0] {
		STRAP_RES,
		STRAP_SHORT,
		STRAP_OPEN,
		STRAP_HIGH
	} strap_kind_e;
	// Host command strobes
	typedef struct packed {
		logic manual_tune;   // Start a run now
		logic store_user;    // Copy compensator set to user store
		logic coeff_write;   // Host coefficient write
		logic nlt_write;     // Transient path write
	} host_cmd_s;
endpackage : loop_tuning_pkg

// File: ms_timer.sv
// Millisecond counter driven by a one-cycle tick enable.
// Assumes tick_i is a single-cycle pulse in the mclk_i domain.
module ms_timer #(
	parameter int W = 17
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_i,
	input  wire logic         clear_i,
	input  wire logic         tick_i,
	output logic [W-1:0]      count_o
);
	// ==========================================================
	// Counter, clear has priority, saturates
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			count_o <= '0;
		end else if (clear_i) begin
			count_o <= '0;
		end else if (tick_i && count_o != '1) begin
			count_o <= count_o + 1'b1;
		end
	end
endmodule : ms_timer

// File: loop_tuning_settings_manager.sv
// Loop tuning scheduler, coefficient source selection and output strap decode.
// Assumes host commands arrive as one-cycle strobes in the mclk_i domain.
// Notes on behaviour
// - Host-writable compensator coefficient set drives loop
// - Default mode tunes after ramp, loads result
// - Tuning run completes within 50 to 200 ms
// - Modes: off, once, every second, every minute
// - Optional single tune per power-up, reuse result
// - Manual trigger command starts a run
// - Gain 10 to 100 percent scales result
// - RAM filled strap, factory, then user store; code loads only the user set, or the safe set when tuning is on
// - Tuning on at power-up loads safe set
// - Off-to-on change loads safe set
// - Store copies whole working RAM to user; code copies only the compensator set, not the transient path
// - On-to-off change loads user store set
// - Tuning off at power-up loads user set
// - Transient path preset safe, host rewritable
// - Strap sampled only at start-up
// - Strap decodes to 28 levels, 0.6-3.3 V
// - Strap level caps requested output voltage
// - Short, open, high give 0.60, 1.2, 2.5
// - Maximum output is 110 percent of strap
// - Output ok immediate after tune, else delay
`include "loop_tuning_map.svh"
module loop_tuning_settings_manager #(
	parameter int                  COEFF_W    = `COEFF_W,
	parameter int                  NLT_W      = 32,
	parameter logic [`COEFF_W-1:0] SAFE_COEFF = 72'h0000000000000000aa, // Arbitrary
	parameter logic [NLT_W-1:0]    SAFE_NLT   = 32'h00000055,           // Arbitrary
	parameter int                  TICK_CYC   = `TICK_CYCLES,
	parameter int                  PER_SEC_MS = `PERIOD_SEC_MS,
	parameter int                  PER_MIN_MS = `PERIOD_MIN_MS
) (
	input  wire logic                              mclk_i,
	input  wire logic                              reset_i,
	input  wire logic                              startup_i,        // Start-up window, strap sampled
	input  wire loop_tuning_pkg::strap_kind_e      strap_kind_i,     // Strap pin condition
	input  wire logic [4:0]                        strap_index_i,    // Resistor bin, 0..27
	input  wire logic [COEFF_W-1:0]                factory_coeffs_i, // Factory store set
	input  wire logic [COEFF_W-1:0]                user_coeffs_i,    // User store set
	input  wire logic                              stores_valid_i,   // Stores readable after power-up
	input  wire loop_tuning_pkg::tune_mode_e       tune_mode_i,      // Tuning schedule
	input  wire logic                              once_per_power_i, // Tune only first ramp
	input  wire logic [6:0]                        gain_pct_i,       // Gain, percent
	input  wire logic                              gain_write_i,     // Gain write strobe
	input  wire loop_tuning_pkg::host_cmd_s        cmd_i,            // Host strobes
	input  wire logic [COEFF_W-1:0]                host_coeffs_i,    // Coefficient write data
	input  wire logic [NLT_W-1:0]                  host_nlt_i,       // Transient path write data
	input  wire logic                              output_enable_i,  // Output enabled level
	input  wire logic                              ramp_done_i,      // Ramp finished pulse
	input  wire logic                              tune_done_i,      // Engine finished pulse
	input  wire logic [COEFF_W-1:0]                tune_coeffs_i,    // Engine raw result
	input  wire logic                              vout_req_i,       // Requested output write
	input  wire logic [11:0]                       vout_req_mv_i,    // Requested output, mV
	input  wire logic                              ok_delay_done_i,  // Configured delay expired
	output logic [COEFF_W-1:0]                     compensator_coeffs_o,
	output logic [NLT_W-1:0]                       nonlinear_transient_path_o,
	output logic                                   tune_start_o,     // Engine start pulse
	output logic                                   tune_busy_o,
	output logic                                   tune_overtime_o,  // Run beyond 200 ms
	output logic                                   user_write_o,     // Store write pulse
	output logic [COEFF_W-1:0]                     user_write_data_o,
	output logic [11:0]                            vout_nom_mv_o,
	output logic [11:0]                            vout_max_mv_o,
	output logic [11:0]                            vout_target_mv_o,
	output logic                                   output_ok_flag_o,
	output logic [6:0]                             gain_pct_o
);
	// ==========================================================
	// Elaboration checks
	if (COEFF_W < 8 || TICK_CYC < 1 || PER_SEC_MS < `TUNE_MAX_MS || PER_MIN_MS < PER_SEC_MS) begin : g_bad_param
		$error("loop_tuning_settings_manager: bad parameter");
	end

	// ==========================================================
	// Strap level table, millivolts
	localparam logic [11:0] LEVEL_MV [`STRAP_LEVELS] = '{
		12'h258, 12'h28a, 12'h2bc, 12'h2ee, 12'h320, 12'h352, 12'h384, 12'h3b6,
		12'h3e8, 12'h41a, 12'h44c, 12'h47e, 12'h4b0, 12'h4e2, 12'h514, 12'h578,
		12'h5dc, 12'h640, 12'h6a4, 12'h708, 12'h76c, 12'h7d0, 12'h834, 12'h898,
		12'h8fc, 12'h9c4, 12'hbb8, 12'hce4};

	// Tick divider, one millisecond enable
	logic [15:0] div_q;
	logic        tick_q;
	wire  logic  div_end = (div_q == 16'(TICK_CYC - 1));

	// Power-up sequencing
	logic        init_done_q;
	logic        strap_taken_q;
	logic        was_off_q;
	logic        have_result_q;
	logic        ok_pending_q;
	logic        tuned_ever_q;
	logic [16:0] run_ms;
	logic [16:0] per_ms;
	logic        per_clear;

	// ==========================================================
	// Decoding
	// Modes
	wire logic tuning_on  = (tune_mode_i != loop_tuning_pkg::MODE_OFF);
	wire logic periodic   = (tune_mode_i == loop_tuning_pkg::MODE_SECOND) ||
	                        (tune_mode_i == loop_tuning_pkg::MODE_MINUTE);
	wire logic [16:0] per_len = (tune_mode_i == loop_tuning_pkg::MODE_MINUTE) ?
	                        17'(PER_MIN_MS) : 17'(PER_SEC_MS);
	wire logic per_due    = periodic && output_enable_i && (per_ms >= per_len);
	// Requests
	wire logic ramp_tune  = tuning_on && ramp_done_i &&
	                        !(once_per_power_i && tuned_ever_q);
	wire logic want_run   = init_done_q && (cmd_i.manual_tune || ramp_tune || per_due);
	wire logic start_run  = want_run && !tune_busy_o;
	wire logic run_ok     = tune_busy_o && tune_done_i;
	wire logic early_done = run_ok && (run_ms < 17'(`TUNE_MIN_MS));
	// Strap
	wire logic [4:0]  idx = (strap_index_i > 5'h1b) ? 5'h1b : strap_index_i;
	wire logic [11:0] strap_mv =
		(strap_kind_i == loop_tuning_pkg::STRAP_SHORT) ? `FIX_SHORT_MV :
		(strap_kind_i == loop_tuning_pkg::STRAP_OPEN)  ? `FIX_OPEN_MV  :
		(strap_kind_i == loop_tuning_pkg::STRAP_HIGH)  ? `FIX_HIGH_MV  :
		LEVEL_MV[idx];
	// Limits
	wire logic [15:0] max_wide = 16'((32'(vout_nom_mv_o) * `LIMIT_NUM) / `LIMIT_DEN);
	wire logic [11:0] max_mv   = (max_wide > 16'h0fff) ? 12'hfff : max_wide[11:0];
	wire logic [11:0] req_cap  = (vout_req_mv_i > vout_max_mv_o) ? vout_max_mv_o :
	                             vout_req_mv_i;

	// Gain scaling of the engine result, per field of 24 bits
	localparam int FW = COEFF_W / 3;
	logic [COEFF_W-1:0] scaled;
	always_comb begin
		scaled = '0;
		for (int f = 0; f < 3; f++) begin
			scaled[f*FW +: FW] = FW'(($signed({{32{tune_coeffs_i[f*FW+FW-1]}},
				tune_coeffs_i[f*FW +: FW]}) * $signed({1'b0, gain_pct_o})) / 100);
		end
	end

	// ==========================================================
	// Millisecond divider
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			div_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_end ? 16'h0000 : div_q + 16'h0001;
			tick_q <= div_end;
		end
	end

	// Run length and period timers
	ms_timer #(.W(17)) u_run_timer (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.clear_i (start_run),
		.tick_i  (tick_q && tune_busy_o),
		.count_o (run_ms)
	);
	assign per_clear = start_run || !periodic || !output_enable_i;
	ms_timer #(.W(17)) u_period_timer (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.clear_i (per_clear),
		.tick_i  (tick_q),
		.count_o (per_ms)
	);

	// ==========================================================
	// Strap capture at start-up only
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			strap_taken_q    <= 1'b0;
			vout_nom_mv_o    <= `VOUT_MIN_MV;
			vout_max_mv_o    <= `VOUT_MIN_MV;
			vout_target_mv_o <= `VOUT_MIN_MV;
		end else begin
			if (startup_i && !strap_taken_q) begin
				// Capture
				strap_taken_q    <= 1'b1;
				vout_nom_mv_o    <= strap_mv;
				vout_target_mv_o <= strap_mv;
			end
			vout_max_mv_o <= max_mv;
			if (vout_req_i && strap_taken_q) begin
				// Capped
				vout_target_mv_o <= req_cap;
			end
		end
	end

	// ==========================================================
	// Tuning run control
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			tune_start_o    <= 1'b0;
			tune_busy_o     <= 1'b0;
			tune_overtime_o <= 1'b0;
			tuned_ever_q    <= 1'b0;
		end else begin
			tune_start_o <= start_run;
			if (start_run) begin
				// New run
				tune_busy_o     <= 1'b1;
				tune_overtime_o <= 1'b0;
			end else if (run_ok && !early_done) begin
				// Accepted
				tune_busy_o  <= 1'b0;
				tuned_ever_q <= 1'b1;
			end else if (tune_busy_o && run_ms >= 17'(`TUNE_MAX_MS)) begin
				// Overrun
				tune_overtime_o <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Gain setting, clamped into range
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			gain_pct_o <= `GAIN_RST_PCT;
		end else if (gain_write_i) begin
			gain_pct_o <= (gain_pct_i < `GAIN_MIN_PCT) ? `GAIN_MIN_PCT :
			              (gain_pct_i > `GAIN_MAX_PCT) ? `GAIN_MAX_PCT : gain_pct_i;
		end
	end

	// ==========================================================
	// Working RAM coefficient source selection
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			init_done_q                <= 1'b0;
			was_off_q                  <= 1'b1;
			have_result_q              <= 1'b0;
			compensator_coeffs_o       <= SAFE_COEFF;
			nonlinear_transient_path_o <= SAFE_NLT;
		end else begin
			if (!init_done_q) begin
				if (stores_valid_i) begin
					init_done_q <= 1'b1;
					was_off_q   <= !tuning_on;
					// Safe set if tuning on, else user set; factory set is only compared
					compensator_coeffs_o <= tuning_on ? SAFE_COEFF : user_coeffs_i;
					if (factory_coeffs_i == user_coeffs_i && tuning_on) begin
						compensator_coeffs_o <= SAFE_COEFF;
					end
				end
			end else if (was_off_q && tuning_on) begin
				// Off to on
				was_off_q            <= 1'b0;
				compensator_coeffs_o <= SAFE_COEFF;
			end else if (!was_off_q && !tuning_on) begin
				// On to off
				was_off_q            <= 1'b1;
				compensator_coeffs_o <= user_coeffs_i;
			end else if (run_ok && !early_done) begin
				// Tuned set
				compensator_coeffs_o <= scaled;
				have_result_q        <= 1'b1;
			end else if (cmd_i.coeff_write) begin
				// Host set
				compensator_coeffs_o <= host_coeffs_i;
			end
			if (cmd_i.nlt_write) begin
				nonlinear_transient_path_o <= host_nlt_i;
			end
		end
	end

	// ==========================================================
	// Store to user memory and output ok flag
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			user_write_o      <= 1'b0;
			user_write_data_o <= '0;
			ok_pending_q      <= 1'b0;
			output_ok_flag_o  <= 1'b0;
		end else begin
			user_write_o <= cmd_i.store_user && init_done_q;
			if (cmd_i.store_user) begin
				user_write_data_o <= compensator_coeffs_o;
			end
			if (!output_enable_i) begin
				// Output off
				ok_pending_q     <= 1'b0;
				output_ok_flag_o <= 1'b0;
			end else if (ramp_done_i) begin
				// Ramp over
				ok_pending_q <= 1'b1;
			end else if (ok_pending_q) begin
				if (tuning_on ? (have_result_q && !tune_busy_o && !start_run) : ok_delay_done_i) begin
					output_ok_flag_o <= 1'b1;
					ok_pending_q     <= 1'b0;
				end
			end
		end
	end
endmodule : loop_tuning_settings_manager

// File: loop_tuning_properties.sv
// Port checker for the loop tuning settings manager.
// Assumes it is bound onto loop_tuning_settings_manager with matching parameters.
module loop_tuning_properties #(
	parameter int COEFF_W  = 72,
	parameter int TICK_CYC = 10
) (
	input wire logic                       mclk_i,
	input wire logic                       reset_i,
	input wire logic                       startup_i,
	input wire loop_tuning_pkg::host_cmd_s cmd_i,
	input wire logic                       gain_write_i,
	input wire logic [6:0]                 gain_pct_i,
	input wire logic                       output_enable_i,
	input wire logic [COEFF_W-1:0]         compensator_coeffs_o,
	input wire logic                       tune_start_o,
	input wire logic                       tune_busy_o,
	input wire logic                       tune_overtime_o,
	input wire logic                       user_write_o,
	input wire logic [COEFF_W-1:0]         user_write_data_o,
	input wire logic [11:0]                vout_nom_mv_o,
	input wire logic [11:0]                vout_max_mv_o,
	input wire logic [11:0]                vout_target_mv_o,
	input wire logic                       output_ok_flag_o,
	input wire logic [6:0]                 gain_pct_o
);
	// ==========================================================
	// Helper counters
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	logic [15:0] run_q;  // Cycles since the last start
	logic [1:0]  seen_q; // Cycles since strap capture, saturating
	// Run length and capture age
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			run_q <= '0;
			seen_q <= '0;
		end else begin
			run_q <= tune_start_o ? 16'h0001 : (tune_busy_o && run_q != 16'hffff) ? run_q + 16'h0001 : run_q;
			seen_q <= seen_q + 2'(seen_q != 2'h3 && (seen_q != 2'h0 || startup_i));
		end
	end
	// ==========================================================
	// Properties
	start_busy_a: assert property (tune_start_o |-> tune_busy_o) else $error("start without busy");
	single_run_a: assert property (tune_start_o |-> !$past(tune_busy_o)) else $error("start while busy");
	store_copy_a: assert property (user_write_o |-> $past(cmd_i.store_user) &&
		user_write_data_o == $past(compensator_coeffs_o)) else $error("store data wrong");
	max_ratio_a: assert property (!$past(reset_i) |->
		16'(vout_max_mv_o) == 16'($past(vout_nom_mv_o)) * 16'h000b / 16'h000a) else $error("max not 110 percent");
	target_cap_a: assert property (16'(vout_target_mv_o) <= 16'(vout_nom_mv_o) * 16'h000b / 16'h000a)
		else $error("target above cap");
	strap_hold_a: assert property (seen_q == 2'h3 |-> $stable(vout_nom_mv_o)) else $error("strap moved");
	gain_clamp_a: assert property (gain_write_i |=> gain_pct_o == ($past(gain_pct_i) < 7'h0a ? 7'h0a :
		($past(gain_pct_i) > 7'h64 ? 7'h64 : $past(gain_pct_i)))) else $error("gain not clamped");
	early_over_a: assert property (tune_busy_o && !tune_start_o && run_q < 16'(199 * TICK_CYC)
		|-> !tune_overtime_o) else $error("overtime too early");
	ok_enable_a: assert property (output_ok_flag_o |-> $past(output_enable_i) || $past(output_enable_i, 2))
		else $error("output ok while disabled");
endmodule : loop_tuning_properties

bind loop_tuning_settings_manager loop_tuning_properties #(.COEFF_W(COEFF_W), .TICK_CYC(TICK_CYC)) i_props (
	.mclk_i(mclk_i), .reset_i(reset_i), .startup_i(startup_i), .cmd_i(cmd_i), .gain_write_i(gain_write_i),
	.gain_pct_i(gain_pct_i), .output_enable_i(output_enable_i), .compensator_coeffs_o(compensator_coeffs_o),
	.tune_start_o(tune_start_o), .tune_busy_o(tune_busy_o), .tune_overtime_o(tune_overtime_o),
	.user_write_o(user_write_o), .user_write_data_o(user_write_data_o), .vout_nom_mv_o(vout_nom_mv_o),
	.vout_max_mv_o(vout_max_mv_o), .vout_target_mv_o(vout_target_mv_o), .output_ok_flag_o(output_ok_flag_o),
	.gain_pct_o(gain_pct_o));

// File: host_model.sv
// Host controller model issuing configuration command strobes.
// Assumes one bench process calls its tasks, starting at a clock edge.
module host_model (
	input  wire logic                 mclk_i,
	output loop_tuning_pkg::host_cmd_s cmd_o,
	output logic [71:0]               coeffs_o,
	output logic [31:0]               nlt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle at time zero
	initial begin
		cmd_o = '0;
		coeffs_o = '0;
		nlt_o = '0;
	end
	// One-cycle strobe with its data; input assumed stable before a tune
	task automatic send(input logic [3:0] c, input logic [71:0] d, input logic [31:0] n);
		@(posedge mclk_i);
		cmd_o <= c;
		coeffs_o <= d;
		nlt_o <= n;
		@(posedge mclk_i);
		cmd_o <= '0;
		coeffs_o <= ~d; // Stale data
		nlt_o <= ~n;
	endtask : send
	// Universal set written, then stored
	task automatic store_universal;
		send(4'h2, 72'h7cb941fdc3417ccd99, '0);
		send(4'h4, '0, '0);
	endtask : store_universal
endmodule : host_model

// File: testbench.sv
// Self-checking bench for the loop tuning settings manager.
// Assumes shortened tick and period parameters; host_model drives commands.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [71:0] SAFE = 72'h0000123456abcdef01; // Safe set, arbitrary
	localparam logic [31:0] NLT  = 32'h0000a5a5;           // Safe transient set, arbitrary
	logic mclk_i, reset_i, startup_i, stores_valid_i, gain_write_i, output_enable_i, ramp_done_i, tune_done_i;
	logic vout_req_i, tune_start_o, tune_busy_o, tune_overtime_o, user_write_o, output_ok_flag_o;
	loop_tuning_pkg::strap_kind_e strap_kind_i;
	loop_tuning_pkg::tune_mode_e  tune_mode_i;
	loop_tuning_pkg::host_cmd_s   cmd_i;
	logic [4:0]  strap_index_i;
	logic [6:0]  gain_pct_i, gain_pct_o, gexp;
	logic [11:0] vout_req_mv_i, vout_nom_mv_o, vout_max_mv_o, vout_target_mv_o, maxv;
	logic [31:0] host_nlt_i, nonlinear_transient_path_o, nv;
	logic [71:0] factory_coeffs_i, user_coeffs_i, host_coeffs_i, tune_coeffs_i, compensator_coeffs_o;
	logic [71:0] user_write_data_o, ram;
	logic [71:0] wq[$], cq[$]; // Expected store data, expected tuned sets
	logic [6:0]  gv[3] = '{7'h05, 7'h7f, 7'h00};
	logic [11:0] vr[2] = '{12'hfff, 12'h258};
	int bad_count = 0, cmp_count = 0;
	logic once_per_power_i = 1'b0, ok_delay_done_i = 1'b0;
	// ==========================================================
	// Design and host
	loop_tuning_settings_manager #(.SAFE_COEFF(SAFE), .SAFE_NLT(NLT), .TICK_CYC(10), .PER_SEC_MS(200),
		.PER_MIN_MS(400)) i_loop_tuning_settings_manager (.mclk_i(mclk_i), .reset_i(reset_i),
		.startup_i(startup_i), .strap_kind_i(strap_kind_i), .strap_index_i(strap_index_i),
		.factory_coeffs_i(factory_coeffs_i), .user_coeffs_i(user_coeffs_i), .stores_valid_i(stores_valid_i),
		.tune_mode_i(tune_mode_i), .once_per_power_i(once_per_power_i), .gain_pct_i(gain_pct_i), .gain_write_i(gain_write_i),
		.cmd_i(cmd_i), .host_coeffs_i(host_coeffs_i), .host_nlt_i(host_nlt_i), .output_enable_i(output_enable_i),
		.ramp_done_i(ramp_done_i), .tune_done_i(tune_done_i), .tune_coeffs_i(tune_coeffs_i),
		.vout_req_i(vout_req_i), .vout_req_mv_i(vout_req_mv_i), .ok_delay_done_i(ok_delay_done_i),
		.compensator_coeffs_o(compensator_coeffs_o), .nonlinear_transient_path_o(nonlinear_transient_path_o),
		.tune_start_o(tune_start_o), .tune_busy_o(tune_busy_o), .tune_overtime_o(tune_overtime_o),
		.user_write_o(user_write_o), .user_write_data_o(user_write_data_o), .vout_nom_mv_o(vout_nom_mv_o),
		.vout_max_mv_o(vout_max_mv_o), .vout_target_mv_o(vout_target_mv_o), .output_ok_flag_o(output_ok_flag_o),
		.gain_pct_o(gain_pct_o));
	host_model i_host_model (.mclk_i(mclk_i), .cmd_o(cmd_i), .coeffs_o(host_coeffs_i), .nlt_o(host_nlt_i));
	// ==========================================================
	// Helpers
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : cyc
	task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	// Strap level in mV for a pin condition and bin
	function automatic logic [11:0] strap_mv(input loop_tuning_pkg::strap_kind_e k, input logic [4:0] i);
		logic [4:0] c;
		c = (i > 5'h1b) ? 5'h1b : i;
		case (k)
			loop_tuning_pkg::STRAP_SHORT: return 12'h258;
			loop_tuning_pkg::STRAP_OPEN: return 12'h4b0;
			loop_tuning_pkg::STRAP_HIGH: return 12'h9c4;
			default: return c < 5'h0f ? 12'h258 + 12'h032 * c : c < 5'h19 ? 12'h578 + 12'h064 * (c - 5'h0f) :
				c == 5'h19 ? 12'h9c4 : c == 5'h1a ? 12'hbb8 : 12'hce4;
		endcase
	endfunction : strap_mv
	// Bounded wait for the engine start pulse
	task automatic wait_start(input int lim);
		int n;
		n = 0;
		while (tune_start_o !== 1'b1 && n < lim) begin
			@(posedge mclk_i);
			n++;
		end
		check("tune_start", tune_start_o, 1'b1);
	endtask : wait_start
	task automatic done_pulse(input logic [71:0] r);
		@(posedge mclk_i);
		tune_done_i <= 1'b1;
		tune_coeffs_i <= r;
		@(posedge mclk_i);
		tune_done_i <= 1'b0;
		tune_coeffs_i <= ~r;
		cyc(4);
	endtask : done_pulse
	// Engine result, noted scaled by the gain
	task automatic finish_run;
		logic [71:0] r;
		r = 72'({$urandom, $urandom, $urandom});
		for (int f = 0; f < 3; f++) ram[24*f +: 24] = 24'($signed(r[24*f +: 24]) * int'(gexp) / 100);
		cq.push_back(ram);
		done_pulse(r);
	endtask : finish_run
	// Reset, strap capture and power-up load
	task automatic power_up(input loop_tuning_pkg::strap_kind_e k, input logic [4:0] i,
		input loop_tuning_pkg::tune_mode_e m);
		reset_i <= 1'b1;
		startup_i <= 1'b0;
		stores_valid_i <= 1'b0;
		output_enable_i <= 1'b0;
		strap_kind_i <= k;
		strap_index_i <= i;
		tune_mode_i <= m;
		user_coeffs_i <= 72'({$urandom, $urandom, $urandom});
		cyc(20);
		reset_i <= 1'b0;
		cyc(2);
		check("reset_coeffs", compensator_coeffs_o, SAFE);
		check("reset_gain", gain_pct_o, 7'h32);
		check("reset_nlt", nonlinear_transient_path_o, NLT);
		startup_i <= 1'b1;
		cyc(3);
		strap_index_i <= ~i;
		stores_valid_i <= 1'b1;
		startup_i <= 1'b0;
		cyc(4);
		maxv = 12'(strap_mv(k, i) * 11 / 10);
		gexp = 7'h32;
		check("vout_nom", vout_nom_mv_o, strap_mv(k, i));
		check("vout_max", vout_max_mv_o, maxv);
		check("power_up_coeffs", compensator_coeffs_o, m == loop_tuning_pkg::MODE_OFF ? user_coeffs_i : SAFE);
	endtask : power_up
	// ==========================================================
	// Result monitor against the oldest note
	always @(posedge mclk_i) begin
		if (user_write_o === 1'b1) begin
			check("user_write_data", user_write_data_o, wq.pop_front());
		end
		if ($fell(tune_busy_o) && reset_i === 1'b0) begin
			check("tuned_coeffs", compensator_coeffs_o, cq.pop_front());
		end
	end
	// Watchdog
	initial begin
		cyc(40000);
		bad_count++;
		finish_test();
	end
	// ==========================================================
	// Main sequence
	initial begin
		{reset_i, startup_i, stores_valid_i, gain_write_i, output_enable_i, ramp_done_i, tune_done_i} = '0;
		{vout_req_i, vout_req_mv_i, gain_pct_i, tune_coeffs_i, strap_index_i, user_coeffs_i} = '0;
		strap_kind_i = loop_tuning_pkg::STRAP_RES;
		tune_mode_i = loop_tuning_pkg::MODE_OFF;
		void'($urandom(91997));
		factory_coeffs_i = 72'({$urandom, $urandom, $urandom});
		gv[2] = 7'($urandom);
		power_up(loop_tuning_pkg::STRAP_SHORT, 5'h00, loop_tuning_pkg::MODE_OFF);
		power_up(loop_tuning_pkg::STRAP_OPEN, 5'h03, loop_tuning_pkg::MODE_ONCE);
		power_up(loop_tuning_pkg::STRAP_HIGH, 5'h1f, loop_tuning_pkg::MODE_OFF);
		power_up(loop_tuning_pkg::STRAP_RES, 5'h1f, loop_tuning_pkg::MODE_ONCE);
		power_up(loop_tuning_pkg::STRAP_RES, 5'h0e, loop_tuning_pkg::MODE_OFF);
		power_up(loop_tuning_pkg::STRAP_RES, 5'($urandom_range(27, 0)), loop_tuning_pkg::MODE_ONCE);
		// Ramp tune: early finish refused, manual request while busy dropped
		output_enable_i <= 1'b1;
		ramp_done_i <= 1'b1;
		@(posedge mclk_i);
		ramp_done_i <= 1'b0;
		wait_start(20);
		i_host_model.send(4'h8, '0, '0);
		cyc(100);
		done_pulse(72'hffffff);
		check("busy_early_done", tune_busy_o, 1'b1);
		cyc(500);
		finish_run();
		check("output_ok", output_ok_flag_o, 1'b1);
		once_per_power_i <= 1'b1;
		ramp_done_i <= 1'b1;
		cyc(1);
		ramp_done_i <= 1'b0;
		cyc(2);
		check("once", tune_busy_o, 1'b0);
		// Gain boundaries and a random gain; last run overruns
		foreach (gv[j]) begin
			@(posedge mclk_i);
			gain_pct_i <= gv[j];
			gain_write_i <= 1'b1;
			@(posedge mclk_i);
			gain_write_i <= 1'b0;
			gexp = gv[j] < 7'h0a ? 7'h0a : (gv[j] > 7'h64 ? 7'h64 : gv[j]);
			i_host_model.send(4'h8, '0, '0);
			wait_start(20);
			check("gain", gain_pct_o, gexp);
			cyc(j == 2 ? 2100 : 600);
			check("overtime", tune_overtime_o, j == 2);
			finish_run();
		end
		// Periodic modes
		for (int m = 2; m < 4; m++) begin
			tune_mode_i <= loop_tuning_pkg::tune_mode_e'(m);
			wait_start(5000);
			cyc(600);
			finish_run();
		end
		wq.push_back(ram);
		i_host_model.send(4'h4, '0, '0);
		tune_mode_i <= loop_tuning_pkg::MODE_OFF;
		cyc(4);
		check("off_coeffs", compensator_coeffs_o, user_coeffs_i);
		wq.push_back(72'h7cb941fdc3417ccd99);
		i_host_model.store_universal();
		cyc(3);
		check("host_coeffs", compensator_coeffs_o, 72'h7cb941fdc3417ccd99);
		tune_mode_i <= loop_tuning_pkg::MODE_ONCE;
		cyc(4);
		check("on_coeffs", compensator_coeffs_o, SAFE);
		nv = $urandom;
		i_host_model.send(4'h1, '0, nv);
		cyc(3);
		check("nlt", nonlinear_transient_path_o, nv);
		foreach (vr[j]) begin
			@(posedge mclk_i);
			vout_req_i <= 1'b1;
			vout_req_mv_i <= vr[j];
			@(posedge mclk_i);
			vout_req_i <= 1'b0;
			cyc(3);
			check("vout_target", vout_target_mv_o, vr[j] > maxv ? maxv : vr[j]);
		end
		finish_test();
	end
endmodule : testbench
